// file: core/psi_map.vh
// register map, field positions and frame constants of the management status block
`ifndef PSI_MAP_VH
`define PSI_MAP_VH

// management register addresses
`define PSI_REG_STATUS        5'h01
`define PSI_REG_ID_HIGH       5'h02
`define PSI_REG_ID_LOW        5'h03

// basic_link_status field positions
`define PSI_BIT_EXT_CAP       0
`define PSI_BIT_JABBER        1
`define PSI_BIT_LINK          2
`define PSI_BIT_AN_ABLE       3
`define PSI_BIT_RFAULT        4
`define PSI_BIT_AN_DONE       5
`define PSI_BIT_PRE_SUP       6
`define PSI_RSVD_MSB          10
`define PSI_RSVD_LSB          7
`define PSI_CAPS_MSB          15
`define PSI_CAPS_LSB          11

// basic_link_status constant and reset values
`define PSI_PRE_SUP_VAL       1'b1
`define PSI_AN_ABLE_VAL       1'b1
`define PSI_EXT_CAP_VAL       1'b1
`define PSI_RSVD_VAL          4'h0
`define PSI_CAPS_VAL          5'h0f
`define PSI_FLAG_RST          1'b0

// identifier field positions: org id bits and their register slots
`define PSI_ORG_HI_MSB        21
`define PSI_ORG_HI_LSB        6
`define PSI_ORG_LO_MSB        5
`define PSI_ORG_LO_LSB        0
`define PSI_MODEL_MSB         9
`define PSI_MODEL_LSB         4
`define PSI_REV_MSB           3
`define PSI_REV_LSB           0

// management frame constants
`define PSI_PREAMBLE_BITS     6'h20
`define PSI_OP_READ           2'h2
`define PSI_OP_WRITE          2'h1
`define PSI_ADDR_BITS         5'h0a
`define PSI_DATA_BITS         5'h10

`endif

// file: core/psi_sync.v
// two-flop synchroniser for pin inputs
`timescale 1ns/1ns
`default_nettype none

module psi_sync #(
  parameter WIDTH = 1
) (
  input  wire             core_clk,
  input  wire             rst,
  input  wire [WIDTH-1:0] async_in,
  output wire [WIDTH-1:0] sync_out
);

  reg [WIDTH-1:0] meta_ff;
  reg [WIDTH-1:0] sync_ff;

  // first stage feeds only the second stage
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      meta_ff <= {WIDTH{1'b0}};
      sync_ff <= {WIDTH{1'b0}};
    end else begin
      meta_ff <= async_in;
      sync_ff <= meta_ff;
    end
  end

  assign sync_out = sync_ff;

endmodule // psi_sync

`default_nettype wire

// file: core/psi_latch_flag.v
// one latched status flag, latch-high or latch-low, re-armed by a read
`timescale 1ns/1ns
`default_nettype none
`include "psi_map.vh"

module psi_latch_flag #(
  parameter LATCH_LOW = 0
) (
  input  wire core_clk,
  input  wire rst,
  input  wire cond,
  input  wire clr,
  output wire flag
);

  reg  flag_ff;
  wire nxt_flag;

  // condition wins over the re-arm, so an event during the read survives
  generate
    if (LATCH_LOW != 0) begin : g_low
      assign nxt_flag = cond & (flag_ff | clr);
    end else begin : g_high
      assign nxt_flag = cond | (flag_ff & ~clr);
    end
  endgenerate

  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      flag_ff <= `PSI_FLAG_RST;
    end else begin
      flag_ff <= nxt_flag;
    end
  end

  assign flag = flag_ff;

endmodule // psi_latch_flag

`default_nettype wire

// file: core/psi_mgmt_regs.v
// management serial responder with status and identifier registers
`timescale 1ns/1ns
`default_nettype none
`include "psi_map.vh"

// Notes on behaviour
// - status bit 6 always reads 1: frames without preamble accepted
// - one 32-one preamble needed after reset, bad opcode or bad turnaround
// - negotiation-complete bit reads 1 only when negotiation has finished
// - remote-fault bit latches on far-end fault or partner notice, clears on read
// - negotiation ability bit always reads 1
// - link bit is latch-low: any link loss reads 0 until next read
// - jabber bit latches high until read or reset, only in 10 megabit mode
// - extended capability bit always reads 1
// - reserved status bits 10:7 always read 0
// - two identifier registers give org id, model and revision
// - first identifier register holds org id bits 21:6
// - second identifier register bits 15:10 hold org id bits 5:0
// - second identifier register bits 9:4 hold the six-bit model number
// - second identifier register bits 3:0 hold the four-bit revision
// - status register sits at management address 1
module psi_mgmt_regs #(
  parameter [21:0] ORG_ID   = 22'h15a5c3, // arbitrary value
  parameter [5:0]  MODEL_NO = 6'h15,      // arbitrary value
  parameter [3:0]  REV_NO   = 4'h3        // arbitrary value
) (
  input  wire       core_clk,
  input  wire       rst,
  input  wire       mdc,
  input  wire       mdio_in,
  output wire       mdio_out,
  output wire       mdio_oe_n,
  input  wire [4:0] phy_addr,
  input  wire       an_complete,
  input  wire       link_ok,
  input  wire       jabber_event,
  input  wire       speed_is_10,
  input  wire       far_end_fault,
  input  wire       lp_remote_fault
);

  // frame states
  localparam [2:0] ST_IDLE  = 3'h0;
  localparam [2:0] ST_START = 3'h1;
  localparam [2:0] ST_OP    = 3'h2;
  localparam [2:0] ST_ADDR  = 3'h3;
  localparam [2:0] ST_TA    = 3'h4;
  localparam [2:0] ST_RDATA = 3'h5;
  localparam [2:0] ST_WDATA = 3'h6;

  wire [1:0]  pin_sync;
  wire        mdc_s;
  wire        mdio_s;
  reg         mdc_d_ff;
  wire        mdc_rise;

  reg  [2:0]  state_ff;
  reg  [4:0]  cnt_ff;
  reg  [5:0]  ones_ff;
  reg         pre_ok_ff;
  reg  [1:0]  op_ff;
  reg  [9:0]  addr_ff;
  reg  [15:0] shreg_ff;
  reg         drive_ff;
  reg         out_ff;
  reg         clr_ff;

  wire        is_read;
  wire        hit;
  wire [4:0]  reg_sel;
  wire [9:0]  nxt_addr;
  wire [1:0]  nxt_op;

  wire        rfault_flag;
  wire        jabber_flag;
  wire        link_flag;
  wire [15:0] status_val;
  wire [15:0] id_high_val;
  wire [15:0] id_low_val;
  reg  [15:0] rd_val;

  // mdc and mdio come from the pins; mdc must be far slower than core_clk
  psi_sync #(
    .WIDTH    (2)
  ) u_pin_sync (
    .core_clk (core_clk),
    .rst      (rst),
    .async_in ({mdc, mdio_in}),
    .sync_out (pin_sync)
  );

  assign mdc_s  = pin_sync[1];
  assign mdio_s = pin_sync[0];

  // edge detect on the synchronised clock only
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      mdc_d_ff <= 1'b0;
    end else begin
      mdc_d_ff <= mdc_s;
    end
  end

  assign mdc_rise = mdc_s & ~mdc_d_ff;

  // latched status flags, re-armed by clr_ff on a status read
  psi_latch_flag #(
    .LATCH_LOW (0)
  ) u_rfault (
    .core_clk  (core_clk),
    .rst       (rst),
    .cond      (far_end_fault | lp_remote_fault),
    .clr       (clr_ff),
    .flag      (rfault_flag)
  );

  psi_latch_flag #(
    .LATCH_LOW (0)
  ) u_jabber (
    .core_clk  (core_clk),
    .rst       (rst),
    .cond      (jabber_event & speed_is_10),
    .clr       (clr_ff),
    .flag      (jabber_flag)
  );

  psi_latch_flag #(
    .LATCH_LOW (1)
  ) u_link (
    .core_clk  (core_clk),
    .rst       (rst),
    .cond      (link_ok),
    .clr       (clr_ff),
    .flag      (link_flag)
  );

  // status word: constants, live negotiation state, latched flags
  assign status_val[`PSI_CAPS_MSB:`PSI_CAPS_LSB] = `PSI_CAPS_VAL;
  assign status_val[`PSI_RSVD_MSB:`PSI_RSVD_LSB] = `PSI_RSVD_VAL;
  assign status_val[`PSI_BIT_PRE_SUP]            = `PSI_PRE_SUP_VAL;
  assign status_val[`PSI_BIT_AN_DONE]            = an_complete;
  assign status_val[`PSI_BIT_RFAULT]             = rfault_flag;
  assign status_val[`PSI_BIT_AN_ABLE]            = `PSI_AN_ABLE_VAL;
  assign status_val[`PSI_BIT_LINK]               = link_flag;
  assign status_val[`PSI_BIT_JABBER]             = jabber_flag;
  assign status_val[`PSI_BIT_EXT_CAP]            = `PSI_EXT_CAP_VAL;

  // identifier words; all 22 org id bits are split across the two registers
  assign id_high_val = ORG_ID[`PSI_ORG_HI_MSB:`PSI_ORG_HI_LSB];
  assign id_low_val  = {ORG_ID[`PSI_ORG_LO_MSB:`PSI_ORG_LO_LSB],
                        MODEL_NO,
                        REV_NO};

  assign reg_sel = addr_ff[4:0];
  assign hit     = (addr_ff[9:5] == phy_addr);
  assign is_read = (op_ff == `PSI_OP_READ);
  assign nxt_addr = {addr_ff[8:0], mdio_s};
  assign nxt_op   = {op_ff[0], mdio_s};

  // read data select; unmapped addresses read as zero
  always @* begin
    if (reg_sel == `PSI_REG_STATUS) begin
      rd_val = status_val;
    end else if (reg_sel == `PSI_REG_ID_HIGH) begin
      rd_val = id_high_val;
    end else if (reg_sel == `PSI_REG_ID_LOW) begin
      rd_val = id_low_val;
    end else begin
      rd_val = 16'h0000;
    end
  end

  // frame engine, advanced on each sampled mdc rising edge
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state_ff  <= ST_IDLE;
      cnt_ff    <= 5'h00;
      ones_ff   <= 6'h00;
      pre_ok_ff <= 1'b0;
      op_ff     <= 2'h0;
      addr_ff   <= 10'h000;
      shreg_ff  <= 16'h0000;
      drive_ff  <= 1'b0;
      out_ff    <= 1'b1;
      clr_ff    <= 1'b0;
    end else begin
      clr_ff <= 1'b0;
      if (mdc_rise) begin
        case (state_ff)
          ST_IDLE: begin
            if (mdio_s) begin
              // count preamble ones, saturating at one full preamble
              if (ones_ff != `PSI_PREAMBLE_BITS) begin
                ones_ff <= ones_ff + 6'h01;
              end
              if (ones_ff == `PSI_PREAMBLE_BITS - 6'h01) begin
                pre_ok_ff <= 1'b1;
              end
            end else if (pre_ok_ff || ones_ff == `PSI_PREAMBLE_BITS) begin
              // first start bit; later frames may skip the preamble
              state_ff <= ST_START;
              ones_ff  <= 6'h00;
            end else begin
              ones_ff <= 6'h00;
            end
          end
          ST_START: begin
            // second start bit must be one, else drop back and wait
            if (mdio_s) begin
              state_ff <= ST_OP;
              cnt_ff   <= 5'h00;
            end else begin
              state_ff <= ST_IDLE;
            end
          end
          ST_OP: begin
            op_ff <= nxt_op;
            if (cnt_ff == 5'h01) begin
              if (nxt_op == `PSI_OP_READ || nxt_op == `PSI_OP_WRITE) begin
                state_ff <= ST_ADDR;
                cnt_ff   <= 5'h00;
              end else begin
                state_ff  <= ST_IDLE;
                pre_ok_ff <= 1'b0;
              end
            end else begin
              cnt_ff <= cnt_ff + 5'h01;
            end
          end
          ST_ADDR: begin
            addr_ff <= nxt_addr;
            if (cnt_ff == `PSI_ADDR_BITS - 5'h01) begin
              state_ff <= ST_TA;
              cnt_ff   <= 5'h00;
            end else begin
              cnt_ff <= cnt_ff + 5'h01;
            end
          end
          ST_TA: begin
            if (is_read) begin
              if (cnt_ff == 5'h00) begin
                // snapshot before re-arming the latched flags
                shreg_ff <= rd_val;
                clr_ff   <= hit && reg_sel == `PSI_REG_STATUS;
                drive_ff <= hit;
                out_ff   <= 1'b0;
                cnt_ff   <= 5'h01;
              end else begin
                out_ff   <= shreg_ff[15];
                shreg_ff <= {shreg_ff[14:0], 1'b0};
                state_ff <= ST_RDATA;
                cnt_ff   <= 5'h01;
              end
            end else begin
              // write turnaround must be one then zero
              if (cnt_ff == 5'h00 && !mdio_s) begin
                state_ff  <= ST_IDLE;
                pre_ok_ff <= 1'b0;
              end else if (cnt_ff == 5'h00) begin
                cnt_ff <= 5'h01;
              end else if (mdio_s) begin
                state_ff  <= ST_IDLE;
                pre_ok_ff <= 1'b0;
              end else begin
                state_ff <= ST_WDATA;
                cnt_ff   <= 5'h00;
              end
            end
          end
          ST_RDATA: begin
            if (cnt_ff == `PSI_DATA_BITS) begin
              // last bit held one full period, now release the line
              drive_ff <= 1'b0;
              out_ff   <= 1'b1;
              state_ff <= ST_IDLE;
              cnt_ff   <= 5'h00;
            end else begin
              out_ff   <= shreg_ff[15];
              shreg_ff <= {shreg_ff[14:0], 1'b0};
              cnt_ff   <= cnt_ff + 5'h01;
            end
          end
          ST_WDATA: begin
            // all registers here are read-only: data is clocked past unused
            if (cnt_ff == `PSI_DATA_BITS - 5'h01) begin
              state_ff <= ST_IDLE;
              cnt_ff   <= 5'h00;
            end else begin
              cnt_ff <= cnt_ff + 5'h01;
            end
          end
          default: begin
            state_ff <= ST_IDLE;
            drive_ff <= 1'b0;
            out_ff   <= 1'b1;
          end
        endcase
      end
    end
  end

  // line driven only during a matching read's turnaround and data
  assign mdio_out  = out_ff;
  assign mdio_oe_n = ~drive_ff;

endmodule // psi_mgmt_regs

`default_nettype wire

// file: bench/psi_mgmt_regs_checker.sv
// concurrent checks on the management pins of the status and identifier block
`timescale 1ns/1ns
`default_nettype none
module psi_mgmt_regs_checker #(
  parameter [21:0] ORG_ID   = 22'h15a5c3,
  parameter [5:0]  MODEL_NO = 6'h15,
  parameter [3:0]  REV_NO   = 4'h3
) (
  input wire logic       core_clk,
  input wire logic       rst,
  input wire logic       mdc,
  input wire logic       mdio_in,
  input wire logic       mdio_out,
  input wire logic       mdio_oe_n,
  input wire logic [4:0] phy_addr,
  input wire logic       an_complete,
  input wire logic       link_ok,
  input wire logic       jabber_event,
  input wire logic       speed_is_10,
  input wire logic       far_end_fault,
  input wire logic       lp_remote_fault
);
  logic        mdc_ff;
  logic        oe_ff;
  logic        an_ff;
  logic [31:0] sh_ff;
  logic [4:0]  ra_ff;
  logic [4:0]  cnt_ff;
  wire         rise  = mdc & ~mdc_ff;
  wire         fell  = ~mdio_oe_n & oe_ff;
  wire         done  = mdio_oe_n & ~oe_ff;
  wire         st_rd = done & (ra_ff == 5'h01);
  // line bits at each mdc rise; register and length of each answer
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      mdc_ff <= 1'b0;
      oe_ff  <= 1'b1;
      an_ff  <= 1'b0;
      sh_ff  <= 32'h0;
      ra_ff  <= 5'h0;
      cnt_ff <= 5'h0;
    end else begin
      mdc_ff <= mdc;
      oe_ff  <= mdio_oe_n;
      if (rise)
        sh_ff <= {sh_ff[30:0], mdio_in};
      if (fell) begin
        ra_ff <= sh_ff[5:1];
        an_ff <= an_complete; // bench holds it steady across a read
      end
      if (mdio_oe_n)
        cnt_ff <= 5'h0;
      else if (rise)
        cnt_ff <= cnt_ff + 5'h01;
    end
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  AST_DRIVE_ONLY_OWN_READ: assert property ($fell(mdio_oe_n) |->
    sh_ff[14:11] == 4'h6 && sh_ff[10:6] == phy_addr)
    else $error("line driven outside an addressed read");
  AST_TA_THEN_HOLD: assert property ($fell(mdio_oe_n) |-> !mdio_out ##1 (!mdio_oe_n) [*8])
    else $error("turnaround not driven low or drive cut short");
  AST_ANSWER_LEN: assert property ($rose(mdio_oe_n) |-> cnt_ff == 5'h11)
    else $error("answer not turnaround plus sixteen bits");
  AST_ID_ORG_HI: assert property (done && ra_ff == 5'h02 |-> sh_ff[15:0] == ORG_ID[21:6])
    else $error("first identifier word wrong");
  AST_ID_ORG_LO: assert property (done && ra_ff == 5'h03 |-> sh_ff[15:10] == ORG_ID[5:0])
    else $error("low org id bits wrong");
  AST_ID_MODEL: assert property (done && ra_ff == 5'h03 |-> sh_ff[9:4] == MODEL_NO)
    else $error("model number wrong");
  AST_ID_REV: assert property (done && ra_ff == 5'h03 |-> sh_ff[3:0] == REV_NO)
    else $error("revision wrong");
  AST_ST_FIXED: assert property (st_rd |-> sh_ff[6] && sh_ff[3] && sh_ff[0])
    else $error("fixed status ability bit low");
  AST_ST_RSVD: assert property (st_rd |-> sh_ff[10:7] == 4'h0)
    else $error("reserved status bits not zero");
  AST_AN_DONE: assert property (st_rd |-> sh_ff[5] == an_ff)
    else $error("negotiation complete bit wrong");
  cover property (st_rd);
  cover property (done && ra_ff == 5'h03);
  cover property ($fell(mdio_oe_n) && an_complete);
endmodule // psi_mgmt_regs_checker

bind psi_mgmt_regs psi_mgmt_regs_checker #(.ORG_ID(ORG_ID), .MODEL_NO(MODEL_NO), .REV_NO(REV_NO))
  u_psi_mgmt_regs_checker (
  .core_clk, .rst, .mdc, .mdio_in, .mdio_out, .mdio_oe_n, .phy_addr, .an_complete,
  .link_ok, .jabber_event, .speed_is_10, .far_end_fault, .lp_remote_fault);
`default_nettype wire

// file: bench/psi_smc.sv
// station management controller model driving mdc and the data line
`timescale 1ns/1ns
`default_nettype none
module psi_smc (
  input  wire logic core_clk,
  input  wire logic mdio_line,
  output var  logic mdc,
  output var  logic m_oe,
  output var  logic m_out
);
  // mdc stands low between frames
  initial begin
    mdc   = 1'b0;
    m_oe  = 1'b0;
    m_out = 1'b1;
  end
  // one slow mdc period, eleven core cycles low and ten high, data set while mdc low
  task automatic bit_cyc(input logic oe, input logic d, output logic smp);
    @(negedge core_clk);
    m_oe  = oe;
    m_out = d;
    repeat (10) @(negedge core_clk);
    mdc = 1'b1;
    smp = mdio_line;
    repeat (10) @(negedge core_clk);
    mdc = 1'b0;
  endtask
  // whole frame, msb first; a read samples turnaround and sixteen data bits
  task automatic frame(input logic pre, input logic [1:0] op, input logic [4:0] pa, input logic [4:0] ra,
                       input logic [15:0] wd, output logic [15:0] rd, output logic ta);
    logic [13:0] hdr;
    logic        s;
    hdr = {2'h1, op, pa, ra};
    rd  = 16'h0;
    ta  = 1'b1;
    if (pre)
      for (int i = 0; i < 32; i++) bit_cyc(1'b1, 1'b1, s);
    for (int i = 13; i >= 0; i--) bit_cyc(1'b1, hdr[i], s);
    if (op == 2'h2) begin
      bit_cyc(1'b0, 1'b1, s);
      bit_cyc(1'b0, 1'b1, ta);
      for (int i = 15; i >= 0; i--) bit_cyc(1'b0, 1'b1, rd[i]);
    end else begin
      bit_cyc(1'b1, 1'b1, s);
      bit_cyc(1'b1, 1'b0, s);
      for (int i = 15; i >= 0; i--) bit_cyc(1'b1, wd[i], s);
    end
    m_oe = 1'b0;
  endtask
endmodule // psi_smc
`default_nettype wire

// file: bench/psi_mgmt_regs_tb.sv
// self-checking bench for the management status and identifier block
`timescale 1ns/1ns
`default_nettype none
module psi_mgmt_regs_tb;
  localparam [21:0] P_ORG   = 22'h2b4d1e; // arbitrary value
  localparam [5:0]  P_MODEL = 6'h2d;      // arbitrary value
  localparam [3:0]  P_REV   = 4'h9;       // arbitrary value
  logic       core_clk, rst, mdc, mdio_out, mdio_oe_n, m_oe, m_out;
  logic [4:0] phy_addr;
  logic       an_complete, link_ok, jabber_event, speed_is_10, far_end_fault, lp_remote_fault;
  int         err_total, checks;
  // pull-up holds the line high when nobody drives
  wire        mdio_line = !mdio_oe_n ? mdio_out : (m_oe ? m_out : 1'b1);

  psi_mgmt_regs #(.ORG_ID(P_ORG), .MODEL_NO(P_MODEL), .REV_NO(P_REV)) u_psi_mgmt_regs (
    .core_clk(core_clk), .rst(rst), .mdc(mdc), .mdio_in(mdio_line), .mdio_out(mdio_out),
    .mdio_oe_n(mdio_oe_n), .phy_addr(phy_addr), .an_complete(an_complete), .link_ok(link_ok),
    .jabber_event(jabber_event), .speed_is_10(speed_is_10), .far_end_fault(far_end_fault),
    .lp_remote_fault(lp_remote_fault));
  psi_smc u_psi_smc (.core_clk(core_clk), .mdio_line(mdio_line), .mdc(mdc), .m_oe(m_oe), .m_out(m_out));

  always #4 core_clk = ~core_clk;

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic rd(input logic pre, input logic [4:0] ra, output logic [15:0] d);
    logic ta;
    u_psi_smc.frame(pre, 2'h2, phy_addr, ra, 16'h0, d, ta);
  endtask
  task automatic wr(input logic [4:0] ra, input logic [15:0] wd);
    logic [15:0] d;
    logic        ta;
    u_psi_smc.frame(1'b0, 2'h1, phy_addr, ra, wd, d, ta);
  endtask
  // expected status word: fixed caps, reserved zero, fixed ability bits
  function automatic logic [15:0] st(input logic an, input logic rf, input logic lk, input logic jb);
    st = {5'h0f, 4'h0, 1'b1, an, rf, 1'b1, lk, jb, 1'b1};
  endfunction
  // event pulse: jabber, far fault, partner fault, link loss
  task automatic pulse(input logic [3:0] m);
    @(negedge core_clk);
    {jabber_event, far_end_fault, lp_remote_fault} = m[3:1];
    link_ok = !m[0];
    repeat (4) @(negedge core_clk);
    {jabber_event, far_end_fault, lp_remote_fault} = 3'h0;
    link_ok = 1'b1;
  endtask
  task automatic t_link;
    logic [15:0] d;
    rd(1'b1, 5'h01, d);
    check(d, st(0, 0, 0, 0));
    rd(1'b0, 5'h01, d);
    check(d, st(0, 0, 1, 0));
    pulse(4'h1);
    rd(1'b0, 5'h01, d);
    check(d, st(0, 0, 0, 0));
    rd(1'b0, 5'h01, d);
    check(d, st(0, 0, 1, 0));
  endtask
  task automatic t_flags;
    logic [15:0] d;
    pulse(4'h8);
    rd(1'b0, 5'h01, d);
    check(d, st(0, 0, 1, 0));
    speed_is_10 = 1'b1;
    pulse(4'hc);
    rd(1'b0, 5'h01, d);
    check(d, st(0, 1, 1, 1));
    rd(1'b0, 5'h01, d);
    check(d, st(0, 0, 1, 0));
    an_complete = 1'b1;
    pulse(4'h2);
    rd(1'b0, 5'h01, d);
    check(d, st(1, 1, 1, 0));
    an_complete = 1'b0;
    rd(1'b0, 5'h01, d);
    check(d, st(0, 0, 1, 0));
    // fault held across a read: the re-arm must not swallow it
    far_end_fault = 1'b1;
    rd(1'b0, 5'h01, d);
    check(d, st(0, 1, 1, 0));
    far_end_fault = 1'b0;
    rd(1'b0, 5'h01, d);
    check(d, st(0, 1, 1, 0));
    rd(1'b0, 5'h01, d);
    check(d, st(0, 0, 1, 0));
  endtask
  task automatic t_write;
    logic [15:0] d;
    pulse(4'h4);
    wr(5'h01, 16'h0000);
    wr(5'h02, 16'hffff);
    rd(1'b0, 5'h01, d);
    check(d, st(0, 1, 1, 0));
    rd(1'b0, 5'h02, d);
    check(d, P_ORG[21:6]);
  endtask
  task automatic t_ident;
    logic [15:0] d;
    rd(1'b0, 5'h03, d);
    check(d, {P_ORG[5:0], P_MODEL, P_REV});
    rd(1'b0, 5'h05, d);
    check(d, 16'h0000);
  endtask
  task automatic t_pre;
    logic [15:0] d;
    logic        ta;
    u_psi_smc.frame(1'b0, 2'h0, phy_addr, 5'h01, 16'h0, d, ta);
    rd(1'b0, 5'h02, d);
    check(d, 16'hffff);
    rd(1'b1, 5'h02, d);
    check(d, P_ORG[21:6]);
    u_psi_smc.frame(1'b0, 2'h2, phy_addr ^ 5'h01, 5'h02, 16'h0, d, ta);
    check(d, 16'hffff);
  endtask
  task automatic end_of_test;
    $display("checks %0d err_total %0d", checks, err_total);
    if (err_total == 0 && checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // stimulus changes on the falling clock edge
  initial begin
    core_clk = 1'b0;
    rst = 1'b1;
    phy_addr = 5'h0b;
    {an_complete, jabber_event, speed_is_10, far_end_fault, lp_remote_fault} = 5'h00;
    link_ok = 1'b1;
    err_total = 0;
    checks = 0;
    repeat (12) @(negedge core_clk);
    rst = 1'b0;
    t_link;
    t_flags;
    t_write;
    t_ident;
    t_pre;
    end_of_test;
  end
  // about twenty frames of some 670 cycles each, twice that with preamble, with ample margin
  initial begin
    #600000;
    err_total++;
    end_of_test;
  end
endmodule // psi_mgmt_regs_tb
`default_nettype wire
